// *** src/axis_ctrl_consts.svh ***
// Purpose: offsets, field positions, reset values and counts of the axis command block
// Assumes: included by bare name from the design module and the properties module
// Notes: offsets are word indexes on the plain register port
`ifndef AXIS_CTRL_CONSTS_SVH
`define AXIS_CTRL_CONSTS_SVH

// register offsets
`define OFS_RUN_CMD 8'h00
`define OFS_MODE_ONE 8'h01
`define OFS_FUNC_TWO 8'h04
`define OFS_POS_STATUS 8'h0c
`define OFS_TARGET_MON 8'h10
`define OFS_SEC_SPEED_COMP 8'h16
`define OFS_LATCHED_POS 8'h18
`define OFS_REV_COUNT 8'h1e
`define OFS_FERR_LIMIT 8'h22
`define OFS_SPEED_AMEND 8'h31
`define OFS_PRESET_TURN 8'h4c
`define OFS_ALARM_STATUS 8'h60
`define OFS_IRQ_STATUS 8'h61
`define OFS_IRQ_MASK 8'h62

// run command word fields
`define RUN_MLOCK_BIT 1
`define RUN_LATCH_BIT 4
`define RUN_ABSRD_BIT 5
`define RUN_PRESET_BIT 6
`define RUN_RELOAD_BIT 7
`define RUN_INTEG_BIT 11
`define RUN_CLRALM_BIT 15

// mode word one fields
`define MODE_FERR_ALARM_BIT 0
`define MODE_SPD_AMEND_BIT 2

// function word two: latch input type field
`define FUNC2_LATCH_LSB 0
`define FUNC2_LATCH_W 3

// position management status fields
`define PST_MLOCK_BIT 0
`define PST_LATCH_DONE_BIT 2
`define PST_ABS_BUSY_BIT 4
`define PST_LOAD_DONE_BIT 8

// alarm status fields
`define ALM_FERR_WARN_BIT 0
`define ALM_FERR_ALARM_BIT 1
`define ALM_ABS_FAIL_BIT 2

// interrupt event positions
`define IRQ_LATCH_BIT 0
`define IRQ_LOAD_BIT 1
`define IRQ_ABS_OK_BIT 2
`define IRQ_ABS_FAIL_BIT 3
`define IRQ_FERR_BIT 4
`define IRQ_W 5

// reset values
`define RST_RUN_CMD 16'h0000
`define RST_MODE_ONE 16'h0000
`define RST_FUNC_TWO 16'h0000
`define RST_IRQ_MASK 5'h00

// absolute read tries, the requested one included
`define ABS_READ_TRIES 2'h2

`endif

// *** src/axis_ctrl_pkg.sv ***
// Purpose: types shared by the axis command block and its bench
// Assumes: constants come from axis_ctrl_consts.svh
// Notes: nothing here is imported; users write axis_ctrl_pkg::name
package axis_ctrl_pkg;

   // control mode of the axis loop
   typedef enum logic [1:0] {
      CTRL_POSITION = 2'b00,
      CTRL_PHASE = 2'b01,
      CTRL_SPEED = 2'b10,
      CTRL_TORQUE = 2'b11
   } ctrl_mode_e;

   // latch trigger selection
   typedef enum logic [2:0] {
      LATCH_SRC_EXT = 3'b000,
      LATCH_SRC_HOME = 3'b001,
      LATCH_SRC_PHASE_C = 3'b010
   } latch_src_e;

   // absolute data read sequencer
   typedef enum logic [1:0] {
      ABS_IDLE = 2'b00,
      ABS_REQ = 2'b01,
      ABS_WAIT = 2'b10
   } abs_state_e;

   // position saved at last power-down
   typedef struct packed {
      logic [31:0] encoder_pos;
      logic [31:0] pulse_pos;
   } saved_pos_s;

   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

endpackage

// *** src/axis_run_command_mode_control.sv ***
// Purpose: per-axis run command and mode word logic of a motion module
// Assumes: scan_tick_i is a one-cycle pulse on sys_clk_i; latch pins are asynchronous
// Notes: clk_en_i low freezes every flip-flop, read data included
`timescale 1ns/10ps
`include "axis_ctrl_consts.svh"

module axis_run_command_mode_control #(
   parameter int POS_W = 32,
   parameter int PIN_SYNC = 2
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire axis_ctrl_pkg::reg_req_s reg_req_i,
   output logic [31:0] reg_rdata_o,
   input wire logic scan_tick_i,
   input wire axis_ctrl_pkg::ctrl_mode_e ctrl_mode_i,
   input wire logic pulses_pending_i,
   input wire logic [POS_W-1:0] motion_step_i,
   output logic [POS_W-1:0] motion_step_o,
   input wire logic [POS_W-1:0] axis_position_i,
   input wire logic latch_ext_pin_i,
   input wire logic latch_home_pin_i,
   input wire logic latch_phase_c_pin_i,
   output logic abs_read_req_o,
   input wire logic abs_read_done_i,
   input wire logic abs_read_ok_i,
   input wire logic rev_wrap_i,
   input wire logic infinite_axis_i,
   input wire logic abs_encoder_i,
   input wire axis_ctrl_pkg::saved_pos_s saved_pos_i,
   output axis_ctrl_pkg::saved_pos_s restored_pos_o,
   output logic restore_load_o,
   output logic integ_clear_o,
   input wire logic [POS_W-1:0] follow_error_i,
   output logic axis_halt_o,
   output logic [POS_W-1:0] speed_comp_o,
   output logic irq_o
);

   // refuse widths the logic cannot serve
   if (POS_W < 16 || POS_W > 32) begin : g_bad_pos_w
      $error("POS_W must lie between 16 and 32");
   end
   if (PIN_SYNC != 2) begin : g_bad_sync
      $error("PIN_SYNC must be 2");
   end

   // zero-extend a 16-bit field onto the read bus
   function automatic logic [31:0] ext16(input logic [15:0] v);
      ext16 = {16'h0000, v};
   endfunction

   // widen a position to the read bus
   function automatic logic [31:0] extpos(input logic [POS_W-1:0] v);
      logic [31:0] w;
      w = '0;
      w[POS_W-1:0] = v;
      extpos = w;
   endfunction

   // magnitude of a signed position value
   function automatic logic [POS_W-1:0] magn(input logic [POS_W-1:0] v);
      magn = v[POS_W-1] ? (~v + {{(POS_W-1){1'b0}}, 1'b1}) : v;
   endfunction

   // ---------------- register file ----------------
   logic [15:0] run_cmd_reg, run_cmd_next;
   logic [15:0] mode_one_reg, mode_one_next;
   logic [15:0] func_two_reg, func_two_next;
   logic [POS_W-1:0] preset_turn_reg, preset_turn_next;
   logic [POS_W-1:0] ferr_limit_reg, ferr_limit_next;
   logic [15:0] speed_amend_reg, speed_amend_next;
   logic [POS_W-1:0] sec_comp_reg, sec_comp_next;
   logic [`IRQ_W-1:0] irq_mask_reg, irq_mask_next;
   logic [31:0] rdata_reg, rdata_next;

   // core state
   logic [15:0] prev_cmd_reg, prev_cmd_next;
   logic mlock_reg, mlock_next;
   logic [POS_W-1:0] target_mon_reg, target_mon_next;
   logic latch_armed_reg, latch_armed_next;
   logic latch_done_reg, latch_done_next;
   logic [POS_W-1:0] latched_pos_reg, latched_pos_next;
   logic [POS_W-1:0] rev_count_reg, rev_count_next;
   logic load_done_reg, load_done_next;
   axis_ctrl_pkg::saved_pos_s restored_reg, restored_next;
   logic restore_load_reg, restore_load_next;
   logic ferr_warn_reg, ferr_warn_next;
   logic ferr_alarm_reg, ferr_alarm_next;
   logic abs_fail_reg, abs_fail_next;
   logic [POS_W-1:0] speed_comp_reg, speed_comp_next;
   logic [`IRQ_W-1:0] irq_stat_reg, irq_stat_next;
   axis_ctrl_pkg::abs_state_e abs_state_reg, abs_state_next;
   logic [1:0] abs_tries_reg, abs_tries_next;

   // latch pin synchronisers and edge memory
   logic [2:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
   logic [2:0] pin_rise;
   logic latch_trig;
   logic [15:0] cmd_rise;
   logic [15:0] pos_status;
   logic [15:0] alarm_status;
   logic [`IRQ_W-1:0] irq_evt;
   logic ferr_over;
   logic wr_hit, rd_irq_stat;

   // two-stage synchroniser, edge taken after the second stage only
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_meta_reg <= 3'h0;
         pin_sync_reg <= 3'h0;
         pin_prev_reg <= 3'h0;
      end else if (clk_en_i) begin
         pin_meta_reg <= {latch_phase_c_pin_i, latch_home_pin_i, latch_ext_pin_i};
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   // trigger selection from the latch input type field
   always_comb begin
      pin_rise = pin_sync_reg & ~pin_prev_reg;
      case (axis_ctrl_pkg::latch_src_e'(func_two_reg[`FUNC2_LATCH_LSB +: `FUNC2_LATCH_W]))
         axis_ctrl_pkg::LATCH_SRC_EXT: latch_trig = pin_rise[0];
         axis_ctrl_pkg::LATCH_SRC_HOME: latch_trig = pin_rise[1];
         axis_ctrl_pkg::LATCH_SRC_PHASE_C: latch_trig = pin_rise[2];
         default: latch_trig = 1'b0;
      endcase
   end

   // per-scan rising edges of the run command bits
   assign cmd_rise = scan_tick_i ? (run_cmd_reg & ~prev_cmd_reg) : 16'h0000;
   assign ferr_over = magn(follow_error_i) > ferr_limit_reg;

   // status words as software sees them
   always_comb begin
      pos_status = 16'h0000;
      pos_status[`PST_MLOCK_BIT] = mlock_reg;
      pos_status[`PST_LATCH_DONE_BIT] = latch_done_reg;
      pos_status[`PST_ABS_BUSY_BIT] = (abs_state_reg != axis_ctrl_pkg::ABS_IDLE);
      pos_status[`PST_LOAD_DONE_BIT] = load_done_reg;
      alarm_status = 16'h0000;
      alarm_status[`ALM_FERR_WARN_BIT] = ferr_warn_reg;
      alarm_status[`ALM_FERR_ALARM_BIT] = ferr_alarm_reg;
      alarm_status[`ALM_ABS_FAIL_BIT] = abs_fail_reg;
   end

   // register writes and registered read data
   always_comb begin
      run_cmd_next = run_cmd_reg;
      mode_one_next = mode_one_reg;
      func_two_next = func_two_reg;
      preset_turn_next = preset_turn_reg;
      ferr_limit_next = ferr_limit_reg;
      speed_amend_next = speed_amend_reg;
      sec_comp_next = sec_comp_reg;
      irq_mask_next = irq_mask_reg;
      rdata_next = 32'h0000_0000;
      wr_hit = reg_req_i.wr;
      rd_irq_stat = reg_req_i.rd && (reg_req_i.addr == `OFS_IRQ_STATUS);
      if (wr_hit) begin
         case (reg_req_i.addr)
            `OFS_RUN_CMD: run_cmd_next = reg_req_i.wdata[15:0];
            `OFS_MODE_ONE: mode_one_next = reg_req_i.wdata[15:0];
            `OFS_FUNC_TWO: func_two_next = reg_req_i.wdata[15:0];
            `OFS_PRESET_TURN: preset_turn_next = reg_req_i.wdata[POS_W-1:0];
            `OFS_FERR_LIMIT: ferr_limit_next = reg_req_i.wdata[POS_W-1:0];
            `OFS_SPEED_AMEND: speed_amend_next = reg_req_i.wdata[15:0];
            `OFS_SEC_SPEED_COMP: sec_comp_next = reg_req_i.wdata[POS_W-1:0];
            `OFS_IRQ_MASK: irq_mask_next = reg_req_i.wdata[`IRQ_W-1:0];
            default: ;
         endcase
      end
      if (reg_req_i.rd) begin
         case (reg_req_i.addr)
            `OFS_RUN_CMD: rdata_next = ext16(run_cmd_reg);
            `OFS_MODE_ONE: rdata_next = ext16(mode_one_reg);
            `OFS_FUNC_TWO: rdata_next = ext16(func_two_reg);
            `OFS_POS_STATUS: rdata_next = ext16(pos_status);
            `OFS_TARGET_MON: rdata_next = extpos(target_mon_reg);
            `OFS_SEC_SPEED_COMP: rdata_next = extpos(sec_comp_reg);
            `OFS_LATCHED_POS: rdata_next = extpos(latched_pos_reg);
            `OFS_REV_COUNT: rdata_next = extpos(rev_count_reg);
            `OFS_FERR_LIMIT: rdata_next = extpos(ferr_limit_reg);
            `OFS_SPEED_AMEND: rdata_next = ext16(speed_amend_reg);
            `OFS_PRESET_TURN: rdata_next = extpos(preset_turn_reg);
            `OFS_ALARM_STATUS: rdata_next = ext16(alarm_status);
            `OFS_IRQ_STATUS: rdata_next = {{(32-`IRQ_W){1'b0}}, irq_stat_reg};
            `OFS_IRQ_MASK: rdata_next = {{(32-`IRQ_W){1'b0}}, irq_mask_reg};
            default: rdata_next = 32'h0000_0000; // unmapped reads zero
         endcase
      end
   end

   // register file flip-flops
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_cmd_reg <= `RST_RUN_CMD;
         mode_one_reg <= `RST_MODE_ONE;
         func_two_reg <= `RST_FUNC_TWO;
         preset_turn_reg <= '0;
         ferr_limit_reg <= '0;
         speed_amend_reg <= 16'h0000;
         sec_comp_reg <= '0;
         irq_mask_reg <= `RST_IRQ_MASK;
         rdata_reg <= 32'h0000_0000;
      end else if (clk_en_i) begin
         run_cmd_reg <= run_cmd_next;
         mode_one_reg <= mode_one_next;
         func_two_reg <= func_two_next;
         preset_turn_reg <= preset_turn_next;
         ferr_limit_reg <= ferr_limit_next;
         speed_amend_reg <= speed_amend_next;
         sec_comp_reg <= sec_comp_next;
         irq_mask_reg <= irq_mask_next;
         rdata_reg <= rdata_next;
      end
   end

   // absolute data read sequencer, retries once on a failed read
   always_comb begin
      abs_state_next = abs_state_reg;
      abs_tries_next = abs_tries_reg;
      abs_fail_next = abs_fail_reg;
      irq_evt = '0;
      case (abs_state_reg)
         axis_ctrl_pkg::ABS_IDLE: begin
            if (cmd_rise[`RUN_ABSRD_BIT]) begin
               abs_tries_next = 2'h1;
               abs_state_next = axis_ctrl_pkg::ABS_REQ;
            end
         end
         axis_ctrl_pkg::ABS_REQ: begin
            abs_state_next = axis_ctrl_pkg::ABS_WAIT;
         end
         axis_ctrl_pkg::ABS_WAIT: begin
            if (abs_read_done_i) begin
               if (abs_read_ok_i) begin
                  irq_evt[`IRQ_ABS_OK_BIT] = 1'b1;
                  abs_state_next = axis_ctrl_pkg::ABS_IDLE;
               end else if (abs_tries_reg < `ABS_READ_TRIES) begin
                  abs_tries_next = abs_tries_reg + 2'h1;
                  abs_state_next = axis_ctrl_pkg::ABS_REQ;
               end else begin
                  abs_fail_next = 1'b1;
                  irq_evt[`IRQ_ABS_FAIL_BIT] = 1'b1;
                  abs_state_next = axis_ctrl_pkg::ABS_IDLE;
               end
            end
         end
         default: abs_state_next = axis_ctrl_pkg::ABS_IDLE;
      endcase
      if (cmd_rise[`RUN_CLRALM_BIT] && !abs_fail_next) begin
         abs_fail_next = 1'b0;
      end else if (cmd_rise[`RUN_CLRALM_BIT] && abs_state_next != axis_ctrl_pkg::ABS_IDLE) begin
         abs_fail_next = 1'b0;
      end else if (cmd_rise[`RUN_CLRALM_BIT] && !irq_evt[`IRQ_ABS_FAIL_BIT]) begin
         abs_fail_next = 1'b0;
      end
      irq_evt[`IRQ_LATCH_BIT] = latch_armed_reg && latch_trig;
      irq_evt[`IRQ_LOAD_BIT] = restore_load_next;
      irq_evt[`IRQ_FERR_BIT] = scan_tick_i && ferr_over;
   end

   // main per-scan command handling
   always_comb begin
      prev_cmd_next = scan_tick_i ? run_cmd_reg : prev_cmd_reg;
      mlock_next = mlock_reg;
      target_mon_next = target_mon_reg;
      latch_armed_next = latch_armed_reg;
      latch_done_next = latch_done_reg;
      latched_pos_next = latched_pos_reg;
      rev_count_next = rev_count_reg;
      load_done_next = load_done_reg;
      restored_next = restored_reg;
      restore_load_next = 1'b0;
      ferr_warn_next = ferr_warn_reg;
      ferr_alarm_next = ferr_alarm_reg;
      speed_comp_next = speed_comp_reg;
      if (scan_tick_i) begin
         // commanded target keeps moving even when locked
         target_mon_next = target_mon_reg + motion_step_i;
         // lock follows the bit only between moves and outside speed or torque
         if (!pulses_pending_i
             && ctrl_mode_i != axis_ctrl_pkg::CTRL_SPEED
             && ctrl_mode_i != axis_ctrl_pkg::CTRL_TORQUE) begin
            mlock_next = run_cmd_reg[`RUN_MLOCK_BIT];
         end
         if (run_cmd_reg[`RUN_PRESET_BIT]) begin
            rev_count_next = preset_turn_reg;
         end
         if (cmd_rise[`RUN_RELOAD_BIT]) begin
            load_done_next = 1'b0;
            if (infinite_axis_i && abs_encoder_i) begin
               restored_next = saved_pos_i;
               restore_load_next = 1'b1;
               load_done_next = 1'b1;
            end
         end
         if (ctrl_mode_i == axis_ctrl_pkg::CTRL_POSITION && mode_one_reg[`MODE_SPD_AMEND_BIT]) begin
            speed_comp_next = POS_W'(sec_comp_reg + POS_W'($signed(speed_amend_reg)));
         end else begin
            speed_comp_next = '0;
         end
      end
      if (rev_wrap_i && !(scan_tick_i && run_cmd_reg[`RUN_PRESET_BIT])) begin
         rev_count_next = rev_count_reg + {{(POS_W-1){1'b0}}, 1'b1};
      end
      // a fresh request arms, relies on software giving a new rising edge
      if (cmd_rise[`RUN_LATCH_BIT]) begin
         latch_armed_next = 1'b1;
         latch_done_next = 1'b0;
      end
      if (!run_cmd_reg[`RUN_LATCH_BIT]) begin
         latch_armed_next = 1'b0;
      end
      if (latch_armed_reg && latch_trig) begin
         latched_pos_next = axis_position_i;
         latch_done_next = 1'b1;
         latch_armed_next = 1'b0;
      end
      // clear first, so a detection in the same scan still sticks
      if (cmd_rise[`RUN_CLRALM_BIT]) begin
         ferr_warn_next = 1'b0;
         ferr_alarm_next = 1'b0;
      end
      if (scan_tick_i && ferr_over) begin
         if (mode_one_reg[`MODE_FERR_ALARM_BIT]) begin
            ferr_alarm_next = 1'b1;
         end else begin
            ferr_warn_next = 1'b1;
         end
      end
      // read clears, a new event in the same cycle wins
      irq_stat_next = (rd_irq_stat ? '0 : irq_stat_reg) | irq_evt;
   end

   // core flip-flops
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_cmd_reg <= 16'h0000;
         mlock_reg <= 1'b0;
         target_mon_reg <= '0;
         latch_armed_reg <= 1'b0;
         latch_done_reg <= 1'b0;
         latched_pos_reg <= '0;
         rev_count_reg <= '0;
         load_done_reg <= 1'b0;
         restored_reg <= '0;
         restore_load_reg <= 1'b0;
         ferr_warn_reg <= 1'b0;
         ferr_alarm_reg <= 1'b0;
         abs_fail_reg <= 1'b0;
         speed_comp_reg <= '0;
         irq_stat_reg <= '0;
         abs_state_reg <= axis_ctrl_pkg::ABS_IDLE;
         abs_tries_reg <= 2'h0;
      end else if (clk_en_i) begin
         prev_cmd_reg <= prev_cmd_next;
         mlock_reg <= mlock_next;
         target_mon_reg <= target_mon_next;
         latch_armed_reg <= latch_armed_next;
         latch_done_reg <= latch_done_next;
         latched_pos_reg <= latched_pos_next;
         rev_count_reg <= rev_count_next;
         load_done_reg <= load_done_next;
         restored_reg <= restored_next;
         restore_load_reg <= restore_load_next;
         ferr_warn_reg <= ferr_warn_next;
         ferr_alarm_reg <= ferr_alarm_next;
         abs_fail_reg <= abs_fail_next;
         speed_comp_reg <= speed_comp_next;
         irq_stat_reg <= irq_stat_next;
         abs_state_reg <= abs_state_next;
         abs_tries_reg <= abs_tries_next;
      end
   end

   // outputs
   assign reg_rdata_o = rdata_reg;
   assign motion_step_o = mlock_reg ? '0 : motion_step_i;
   assign abs_read_req_o = (abs_state_reg == axis_ctrl_pkg::ABS_REQ);
   assign restored_pos_o = restored_reg;
   assign restore_load_o = restore_load_reg;
   assign integ_clear_o = run_cmd_reg[`RUN_INTEG_BIT];
   assign axis_halt_o = ferr_alarm_reg;
   assign speed_comp_o = speed_comp_reg;
   assign irq_o = |(irq_stat_reg & irq_mask_reg);

endmodule // axis_run_command_mode_control

// *** verification/axis_run_command_mode_control_properties.sv ***
// Purpose: concurrent checks on the axis command block ports
// Assumes: one clock, async active-low reset, clk_en_i held high
// Notes: bound to every instance of the block
`timescale 1ns/10ps
`include "axis_ctrl_consts.svh"
module axis_run_command_mode_control_properties #(
   parameter int POS_W = 32
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire axis_ctrl_pkg::reg_req_s reg_req_i,
   input wire logic scan_tick_i,
   input wire axis_ctrl_pkg::ctrl_mode_e ctrl_mode_i,
   input wire logic pulses_pending_i,
   input wire logic [POS_W-1:0] motion_step_i,
   input wire logic [POS_W-1:0] motion_step_o,
   input wire logic abs_read_req_o,
   input wire logic infinite_axis_i,
   input wire logic abs_encoder_i,
   input wire logic restore_load_o,
   input wire logic integ_clear_o,
   input wire logic [POS_W-1:0] follow_error_i,
   input wire logic axis_halt_o,
   input wire logic [POS_W-1:0] speed_comp_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic lk, lk_reg, pend_reg, fast_reg, integ_reg, integ_next, amend_reg, amend_next;
   // lock shows as a step that differs from the profile step
   assign lk = motion_step_o != motion_step_i;
   // shadow copies of the written integration and amend bits
   always_comb begin
      integ_next = integ_reg;
      amend_next = amend_reg;
      if (reg_req_i.wr && reg_req_i.addr == `OFS_RUN_CMD) integ_next = reg_req_i.wdata[11];
      if (reg_req_i.wr && reg_req_i.addr == `OFS_MODE_ONE) amend_next = reg_req_i.wdata[2];
   end
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {lk_reg, pend_reg, fast_reg, integ_reg, amend_reg} <= '0;
      end else begin
         {lk_reg, pend_reg, fast_reg} <= {lk, pulses_pending_i, ctrl_mode_i[1]};
         {integ_reg, amend_reg} <= {integ_next, amend_next};
      end
   end
   AST_LOCK_FORM: assert property (lk |-> motion_step_o == '0)
      else $error("locked step not zero");
   AST_LOCK_PEND: assert property ((pend_reg && $stable(motion_step_i) && motion_step_i != '0)
      |-> lk == lk_reg) else $error("lock moved with pulses pending");
   AST_LOCK_MODE: assert property ((fast_reg && $stable(motion_step_i) && motion_step_i != '0)
      |-> lk == lk_reg) else $error("lock moved in speed or torque mode");
   AST_INTEG: assert property ($stable(integ_reg) |-> integ_clear_o == integ_reg)
      else $error("integral clear differs from command bit");
   AST_RELOAD_QUAL: assert property (restore_load_o |-> $past(infinite_axis_i) && $past(abs_encoder_i))
      else $error("reload on unqualified axis");
   AST_HALT_CAUSE: assert property ($rose(axis_halt_o) |-> $past(follow_error_i) != '0)
      else $error("halt without following error");
   AST_SPEED_OFF: assert property (($past(scan_tick_i) && ($past(ctrl_mode_i) !=
      axis_ctrl_pkg::CTRL_POSITION || !$past(amend_reg))) |-> speed_comp_o == '0)
      else $error("speed amend applied while disabled");
   AST_ABS_PULSE: assert property (abs_read_req_o |=> !abs_read_req_o)
      else $error("read request longer than one cycle");
endmodule // axis_run_command_mode_control_properties

bind axis_run_command_mode_control axis_run_command_mode_control_properties #(.POS_W(POS_W)) chk (
   .sys_clk_i, .rst_n_i, .reg_req_i, .scan_tick_i, .ctrl_mode_i, .pulses_pending_i, .motion_step_i,
   .motion_step_o, .abs_read_req_o, .infinite_axis_i, .abs_encoder_i, .restore_load_o,
   .integ_clear_o, .follow_error_i, .axis_halt_o, .speed_comp_o);

// *** verification/abs_encoder_model.sv ***
// Purpose: encoder side answering absolute data read attempts
// Assumes: one request pulse per attempt
// Notes: pattern_i bit picks the result of alternate attempts
`timescale 1ns/10ps
module abs_encoder_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic req_i,
   input wire logic [1:0] pattern_i,
   output logic done_o,
   output logic ok_o
);
   logic [2:0] dly;
   logic idx;
   // answer three cycles after each request; idle result line toggles
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {dly, idx, done_o, ok_o} <= '0;
      end else begin
         done_o <= 1'b0;
         ok_o <= ~ok_o;
         if (req_i) dly <= 3'h3;
         else if (dly != 3'h0) dly <= dly - 3'h1;
         if (dly == 3'h1) begin
            done_o <= 1'b1;
            ok_o <= pattern_i[idx];
            idx <= ~idx;
         end
      end
   end
endmodule // abs_encoder_model

// *** verification/axis_run_command_mode_control_tb.sv ***
// Purpose: self-checking bench of the axis command block
// Assumes: clk_en_i high, phase-c pin and turn wrap idle
// Notes: each scenario drives registers and scans, then compares
`timescale 1ns/10ps
module axis_run_command_mode_control_tb;
   logic sys_clk_i = 0, rst_n_i = 0, clk_en_i = 1, scan_tick_i = 0, pulses_pending_i = 0;
   logic latch_ext_pin_i = 0, latch_home_pin_i = 0, latch_phase_c_pin_i = 0, rev_wrap_i = 0;
   logic abs_read_req_o, abs_read_done_i, abs_read_ok_i, restore_load_o, integ_clear_o;
   logic infinite_axis_i = 0, abs_encoder_i = 0, axis_halt_o, irq_o;
   logic [1:0] pattern = 0;
   logic [31:0] reg_rdata_o, v, e, motion_step_o, speed_comp_o;
   logic [31:0] motion_step_i = 0, axis_position_i = 32'h1234, follow_error_i = 0;
   axis_ctrl_pkg::reg_req_s reg_req_i = '0;
   axis_ctrl_pkg::ctrl_mode_e ctrl_mode_i = axis_ctrl_pkg::CTRL_POSITION;
   axis_ctrl_pkg::saved_pos_s saved_pos_i = '{32'h11, 32'h22}, restored_pos_o;
   int bad_count = 0, total_checks = 0, nreq = 0, n0 = 0;
   always #4 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) if (abs_read_req_o === 1'b1) nreq++;
   axis_run_command_mode_control dut (.sys_clk_i, .rst_n_i, .clk_en_i, .reg_req_i, .reg_rdata_o,
      .scan_tick_i, .ctrl_mode_i, .pulses_pending_i, .motion_step_i, .motion_step_o,
      .axis_position_i, .latch_ext_pin_i, .latch_home_pin_i, .latch_phase_c_pin_i,
      .abs_read_req_o, .abs_read_done_i, .abs_read_ok_i, .rev_wrap_i, .infinite_axis_i,
      .abs_encoder_i, .saved_pos_i, .restored_pos_o, .restore_load_o, .integ_clear_o,
      .follow_error_i, .axis_halt_o, .speed_comp_o, .irq_o);
   abs_encoder_model enc (.clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(abs_read_req_o),
      .pattern_i(pattern), .done_o(abs_read_done_i), .ok_o(abs_read_ok_i));
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i) reg_req_i <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk_i) reg_req_i.wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge sys_clk_i) reg_req_i <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge sys_clk_i) reg_req_i.rd <= 1'b0;
      @(negedge sys_clk_i) v = reg_rdata_o;
   endtask
   task scan;
      @(posedge sys_clk_i) scan_tick_i <= 1'b1;
      @(posedge sys_clk_i) scan_tick_i <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
   endtask
   // reset values, unmapped read, integration clear
   task t_regs;
      rd(8'h00); chk("run cmd", 0, v);
      rd(8'h01); chk("mode one", 0, v);
      rd(8'hff); chk("unmapped", 0, v);
      wr(8'h00, 32'h800); scan; chk("integ", 1, integ_clear_o);
   endtask
   // lock waits for pulses, freezes motion, ignored in speed mode
   task t_lock;
      motion_step_i <= 32'h5; pulses_pending_i <= 1'b1;
      wr(8'h00, 32'h2); scan; chk("lock pend", 5, motion_step_o);
      pulses_pending_i <= 1'b0; scan; chk("lock on", 0, motion_step_o);
      rd(8'h0c); chk("lock flag", 1, v);
      rd(8'h10); e = v + 5; scan; rd(8'h10); chk("target", e, v);
      ctrl_mode_i <= axis_ctrl_pkg::CTRL_SPEED; wr(8'h00, 0); scan;
      chk("lock kept", 0, motion_step_o);
      ctrl_mode_i <= axis_ctrl_pkg::CTRL_POSITION; scan; chk("lock off", 5, motion_step_o);
      motion_step_i <= 0;
   endtask
   // arm, capture on home pin, rearm by fresh rise
   task t_latch;
      wr(8'h04, 1); wr(8'h00, 32'h10); scan;
      latch_home_pin_i <= 1; scan; rd(8'h18); chk("latched", 32'h1234, v);
      rd(8'h0c); chk("latch done", 4, v);
      wr(8'h00, 0); axis_position_i <= 32'h5678; latch_home_pin_i <= 0; scan;
      wr(8'h00, 32'h10); scan; latch_home_pin_i <= 1; scan;
      rd(8'h18); chk("rearmed", 32'h5678, v);
   endtask
   // two failed tries raise alarm; fail then ok retries once
   task t_abs;
      n0 = nreq; wr(8'h00, 32'h20); scan; scan; chk("tries", n0 + 2, nreq);
      rd(8'h60); chk("abs fail", 4, v); rd(8'h61); chk("irq fail", 9, v);
      pattern <= 2'b10; wr(8'h00, 0); scan; wr(8'h00, 32'h20); scan; scan;
      chk("retry", n0 + 4, nreq); rd(8'h61); chk("irq ok", 4, v);
      wr(8'h00, 32'h8000); scan; rd(8'h60); chk("abs clear", 0, v);
   endtask
   // warning keeps running, alarm halts, clear-alarm rise clears both
   task t_ferr;
      wr(8'h22, 32'h10); wr(8'h62, 32'h10); follow_error_i <= 32'hffff_ffef; scan;
      rd(8'h60); chk("warn", 1, v); chk("runs", 0, axis_halt_o);
      chk("irq", 1, irq_o);
      wr(8'h01, 1); scan; chk("halt", 1, axis_halt_o);
      follow_error_i <= 0; wr(8'h00, 0); scan; wr(8'h00, 32'h8000); scan;
      rd(8'h60); chk("ferr clear", 0, v); chk("halt off", 0, axis_halt_o);
   endtask
   // preset, qualified reload, speed amend on and off
   task t_load;
      wr(8'h4c, 7); wr(8'h00, 32'h40); scan; rd(8'h1e); chk("preset", 7, v);
      wr(8'h00, 32'h80); scan; chk("unqualified", 0, restored_pos_o.pulse_pos);
      {infinite_axis_i, abs_encoder_i} <= 2'h3; wr(8'h00, 0); scan; wr(8'h00, 32'h80); scan;
      chk("restored", 32'h22, restored_pos_o.pulse_pos);
      rd(8'h0c); chk("load done", 32'h104, v);
      wr(8'h31, 32'hfffe); wr(8'h16, 32'h10); wr(8'h01, 32'h4); scan;
      chk("amend on", 32'he, speed_comp_o);
      wr(8'h01, 0); scan; chk("amend off", 0, speed_comp_o);
   endtask
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      bad_count++;
      close_out;
   end
   initial begin
      repeat (20) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      t_regs;
      t_lock;
      t_latch;
      t_abs;
      t_ferr;
      t_load;
      close_out;
   end
endmodule // axis_run_command_mode_control_tb
